// ==== shared/acc_map.svh ====
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ACC_ADDR_RESULT     8'h00
`define ACC_ADDR_CSR        8'h04
`define ACC_ADDR_IRQ_STAT   8'h08
`define ACC_ADDR_IRQ_MASK   8'h0C
`define ACC_ADDR_CTRL       8'h10
// ------------------------------------------------------------
// csr fields and reset values
// ------------------------------------------------------------
`define ACC_CSR_DONE_BIT    7
`define ACC_CSR_ON_BIT      5
`define ACC_CSR_ZERO_BIT    4
`define ACC_CSR_CH_HI       2
`define ACC_CSR_CH_LO       0
`define ACC_CSR_RESET       8'h00
`define ACC_RESULT_RESET    8'h00
`define ACC_CODE_FULL       8'hFF
`define ACC_CODE_ZERO       8'h00
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ACC_CONV_CPU_CYC    64
`define ACC_SAMPLE_CPU_X2   63
`define ACC_STAB_NS         30000
`define ACC_CLK_NS          4
`define ACC_AXI_OKAY        2'b00
`define ACC_AXI_SLVERR      2'b10
`endif

// ==== shared/acc_pkg.sv ====
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_OFF    = 2'b00,
    ACC_STAB   = 2'b01,
    ACC_SAMPLE = 2'b10,
    ACC_CONV   = 2'b11
  } acc_phase_t;

  typedef struct packed {
    logic       done;
    logic       on;
    logic [2:0] chan;
  } acc_csr_t;

  typedef struct packed {
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acc_axi_t;

  typedef struct packed {
    acc_axi_t    axi;
    acc_csr_t    conversion_control_status;
    logic [7:0]  result;
    acc_phase_t  phase;
    logic [19:0] cnt;
    logic [1:0]  bitpos_unused;
    logic [7:0]  sar;
    logic [3:0]  bitn;
    logic        settled;
    logic        halted;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [2:0]  chan_out;
    logic        sample;
    logic        conv_on;
    logic [7:0]  dac;
  } acc_state_t;
endpackage : acc_pkg

// ==== logic/acc_top.sv ====
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "acc_map.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module acc_top #(
  parameter int unsigned STAB_CYCLES = (`ACC_STAB_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // power mode and analog core
  input  wire logic        halt_mode,
  input  wire logic        cmp_above,
  output logic [2:0]       channel_select,
  output logic             sample_hold,
  output logic             converter_on,
  output logic [7:0]       dac_code,
  // interrupt
  output logic             irq
);

  acc_pkg::acc_state_t s_r;
  acc_pkg::acc_state_t s_nxt;

  localparam int unsigned CONV_CYC = `ACC_CONV_CPU_CYC;
  // sampling of 31.5 clocks: the hold edge lands mid-cycle, so sampling
  // covers 32 whole clocks and the sar steps sit in the remaining 32
  localparam int unsigned SAMPLE_CYC = (`ACC_SAMPLE_CPU_X2 + 1) / 2;
  localparam int unsigned STEP_CYC   = (CONV_CYC - SAMPLE_CYC) / 8;

  function automatic logic [31:0] acc_word(input logic [7:0] b);
    acc_word = {24'h0000_00, b};
  endfunction : acc_word

  function automatic logic acc_mapped(input logic [7:0] a);
    acc_mapped = (a == `ACC_ADDR_RESULT) || (a == `ACC_ADDR_CSR) || (a == `ACC_ADDR_IRQ_STAT) ||
                 (a == `ACC_ADDR_IRQ_MASK) || (a == `ACC_ADDR_CTRL);
  endfunction : acc_mapped

  logic wr_fire;
  logic rd_fire;
  logic csr_wr;
  logic res_rd;
  logic ended;
  logic aborted;

  assign wr_fire = s_r.axi.aw_got && s_r.axi.w_got && !s_r.axi.bvalid;
  assign rd_fire = s_axi_arvalid && !s_r.axi.rvalid;
  assign csr_wr  = wr_fire && (s_r.axi.aw_addr == `ACC_ADDR_CSR) && s_r.axi.w_strb[0];
  assign res_rd  = rd_fire && (s_axi_araddr == `ACC_ADDR_RESULT);

  always_comb begin
    logic [7:0] csr_rd;
    logic [7:0] wb;
    logic [7:0] trial;
    s_nxt   = s_r;
    csr_rd  = 8'h00;
    wb      = s_r.axi.w_data[7:0];
    trial   = 8'h00;
    ended   = 1'b0;
    aborted = 1'b0;
    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    if (s_axi_awvalid && !s_r.axi.aw_got) begin
      s_nxt.axi.aw_got  = 1'b1;
      s_nxt.axi.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.axi.w_got) begin
      s_nxt.axi.w_got  = 1'b1;
      s_nxt.axi.w_data = s_axi_wdata;
      s_nxt.axi.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.axi.aw_got = 1'b0;
      s_nxt.axi.w_got  = 1'b0;
      s_nxt.axi.bvalid = 1'b1;
      s_nxt.axi.bresp  = acc_mapped(s_r.axi.aw_addr) ? `ACC_AXI_OKAY : `ACC_AXI_SLVERR;
      if (s_r.axi.w_strb[0]) begin
        unique case (s_r.axi.aw_addr)
          `ACC_ADDR_CSR: begin
            // reserved bits 6, 4, 3 are simply not stored
            s_nxt.conversion_control_status.on   = wb[`ACC_CSR_ON_BIT];
            s_nxt.conversion_control_status.chan = wb[`ACC_CSR_CH_HI:`ACC_CSR_CH_LO];
          end
          `ACC_ADDR_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~wb[1:0];
          `ACC_ADDR_IRQ_MASK: s_nxt.irq_mask = wb[1:0];
          default: ;
        endcase
      end
    end
    if (s_r.axi.bvalid && s_axi_bready) begin
      s_nxt.axi.bvalid = 1'b0;
    end
    csr_rd[`ACC_CSR_DONE_BIT]                  = s_r.conversion_control_status.done;
    csr_rd[`ACC_CSR_ON_BIT]                    = s_r.conversion_control_status.on;
    csr_rd[`ACC_CSR_ZERO_BIT]                  = 1'b0;
    csr_rd[`ACC_CSR_CH_HI:`ACC_CSR_CH_LO]      = s_r.conversion_control_status.chan;
    if (rd_fire) begin
      s_nxt.axi.rvalid = 1'b1;
      s_nxt.axi.rresp  = acc_mapped(s_axi_araddr) ? `ACC_AXI_OKAY : `ACC_AXI_SLVERR;
      unique case (s_axi_araddr)
        `ACC_ADDR_RESULT:   s_nxt.axi.rdata = acc_word(s_r.result);
        `ACC_ADDR_CSR:      s_nxt.axi.rdata = acc_word(csr_rd);
        `ACC_ADDR_IRQ_STAT: s_nxt.axi.rdata = acc_word({6'b00_0000, s_r.irq_stat});
        `ACC_ADDR_IRQ_MASK: s_nxt.axi.rdata = acc_word({6'b00_0000, s_r.irq_mask});
        `ACC_ADDR_CTRL:     s_nxt.axi.rdata = acc_word({5'b0_0000, s_r.halted, s_r.settled, s_r.conv_on});
        default:            s_nxt.axi.rdata = 32'h0000_0000;
      endcase
    end
    if (s_r.axi.rvalid && s_axi_rready) begin
      s_nxt.axi.rvalid = 1'b0;
    end
    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    s_nxt.halted = halt_mode;
    if (!s_nxt.conversion_control_status.on || halt_mode) begin
      // off, or halted: stop now, nothing completes; wait mode is not an input at all
      aborted       = (s_r.phase == acc_pkg::ACC_SAMPLE) || (s_r.phase == acc_pkg::ACC_CONV);
      s_nxt.phase   = acc_pkg::ACC_OFF;
      s_nxt.cnt     = 20'h0_0000;
      s_nxt.settled = 1'b0;
    end else if (csr_wr && s_r.phase != acc_pkg::ACC_OFF && s_r.phase != acc_pkg::ACC_STAB) begin
      // fresh conversion with the new channel
      aborted     = 1'b1;
      s_nxt.phase = acc_pkg::ACC_SAMPLE;
      s_nxt.cnt   = 20'h0_0000;
    end else begin
      unique case (s_r.phase)
        acc_pkg::ACC_OFF: begin
          s_nxt.phase = acc_pkg::ACC_STAB;
          s_nxt.cnt   = 20'h0_0000;
        end
        acc_pkg::ACC_STAB: begin
          // converter is on during settling, but no sampling or conversion starts until it ends
          if (s_r.cnt == 20'(STAB_CYCLES - 1)) begin
            s_nxt.settled = 1'b1;
            s_nxt.phase   = acc_pkg::ACC_SAMPLE;
            s_nxt.cnt     = 20'h0_0000;
          end else begin
            s_nxt.cnt = s_r.cnt + 20'h0_0001;
          end
        end
        acc_pkg::ACC_SAMPLE: begin
          s_nxt.cnt = s_r.cnt + 20'h0_0001;
          if (s_r.cnt == 20'(SAMPLE_CYC - 1)) begin
            s_nxt.phase = acc_pkg::ACC_CONV;
            s_nxt.sar   = 8'h00;
            s_nxt.bitn  = 4'h7;
          end
        end
        acc_pkg::ACC_CONV: begin
          s_nxt.cnt = s_r.cnt + 20'h0_0001;
          trial     = s_r.sar | (8'h01 << s_r.bitn[2:0]);
          // binary search on a monotonic comparator keeps codes monotonic and
          // saturates at ffh / 00h with no overflow output
          if (s_r.cnt[1:0] == 2'(STEP_CYC - 1)) begin
            if (cmp_above) begin
              s_nxt.sar = trial;
            end
            s_nxt.bitn = s_r.bitn - 4'h1;
          end
          if (s_r.cnt == 20'(CONV_CYC - 1)) begin
            ended        = 1'b1;
            s_nxt.result = cmp_above ? trial : s_r.sar;
            s_nxt.phase  = acc_pkg::ACC_SAMPLE;
            s_nxt.cnt    = 20'h0_0000;
          end
        end
        default: ;
      endcase
    end
    // ------------------------------------------------------------
    // done flag: set wins over the result-read clear, a csr write clear wins over set
    // ------------------------------------------------------------
    if (csr_wr || res_rd) begin
      s_nxt.conversion_control_status.done = 1'b0;
    end
    if (ended && !csr_wr) begin
      s_nxt.conversion_control_status.done = 1'b1;
    end
    // ------------------------------------------------------------
    // status interrupts: end and abort events only, never from done
    // ------------------------------------------------------------
    if (ended) begin
      s_nxt.irq_stat[0] = 1'b1;
    end
    if (aborted) begin
      s_nxt.irq_stat[1] = 1'b1;
    end
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
    s_nxt.chan_out = s_nxt.conversion_control_status.chan;
    s_nxt.sample   = (s_nxt.phase == acc_pkg::ACC_SAMPLE);
    s_nxt.conv_on  = (s_nxt.phase != acc_pkg::ACC_OFF);
    s_nxt.dac      = (s_nxt.phase == acc_pkg::ACC_CONV) ?
                     (s_nxt.sar | (8'h01 << s_nxt.bitn[2:0])) : `ACC_CODE_ZERO;
    s_nxt.bitpos_unused = 2'b00;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.conversion_control_status      <= '0;
      s_r.result   <= `ACC_RESULT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready  = !s_r.axi.aw_got;
  assign s_axi_wready   = !s_r.axi.w_got;
  assign s_axi_arready  = !s_r.axi.rvalid;
  assign s_axi_bvalid   = s_r.axi.bvalid;
  assign s_axi_bresp    = s_r.axi.bresp;
  assign s_axi_rvalid   = s_r.axi.rvalid;
  assign s_axi_rdata    = s_r.axi.rdata;
  assign s_axi_rresp    = s_r.axi.rresp;
  assign channel_select = s_r.chan_out;
  assign sample_hold    = s_r.sample;
  assign converter_on   = s_r.conv_on;
  assign dac_code       = s_r.dac;
  assign irq            = s_r.irq;

endmodule : acc_top

// ==== dv/acc_top_properties.sv ====
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_top_properties #(
  parameter int unsigned STAB_CYCLES = 4
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // converter
  input wire logic        halt_mode,
  input wire logic        sample_hold,
  input wire logic        converter_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] aw_r;
  logic       bv_r;
  logic [6:0] sh_r;
  // a csr write restarts sampling, so the length count starts over there
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_r <= 8'h00;
      bv_r <= 1'h0;
      sh_r <= 7'h00;
    end else begin
      aw_r <= (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_r;
      bv_r <= s_axi_bvalid;
      sh_r <= !sample_hold ? 7'h00 : (s_axi_bvalid && !bv_r && aw_r == `ACC_ADDR_CSR) ? 7'h01 : sh_r + 7'h01;
    end
  end
  sequence s_stab;
    !sample_hold [*4];
  endsequence
  property p_on_gate;  sample_hold |-> converter_on; endproperty
  property p_samp_len; $fell(sample_hold) && converter_on |-> sh_r == 7'h20; endproperty
  property p_repeat;   $fell(sample_hold) && converter_on |-> ##32 (sample_hold || !converter_on); endproperty
  property p_halt;     halt_mode |-> ##[1:2] !converter_on; endproperty
  property p_stab;     $rose(converter_on) |-> s_stab; endproperty
  property p_b_drop;   s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_r_ans;    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_drop;   s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_r_width;  s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_on_gate: assert property (p_on_gate) else $error("sampling while off");
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
  a_repeat: assert property (p_repeat) else $error("no automatic restart");
  a_halt: assert property (p_halt) else $error("converter runs in halt");
  a_stab: assert property (p_stab) else $error("sampling before settling");
  a_b_drop: assert property (p_b_drop) else $error("write response held");
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  a_r_drop: assert property (p_r_drop) else $error("read data held");
  a_r_width: assert property (p_r_width) else $error("upper read bits set");
endmodule : acc_top_properties
bind acc_top acc_top_properties #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .halt_mode(halt_mode),
  .sample_hold(sample_hold), .converter_on(converter_on));

// ==== dv/acc_analog_model.sv ====
`timescale 1ns/1ps
module acc_analog_model (
  // clock
  input wire logic            ref_clk,
  // converter side
  input wire logic [2:0]      channel_select,
  input wire logic            sample_hold,
  input wire logic [7:0]      dac_code,
  output logic                cmp_above,
  // pin levels in half-lsb steps
  input wire logic [7:0][8:0] level
);
  logic [8:0] held_r;
  // track while sampling, hold during the bit trials
  always_ff @(posedge ref_clk) begin
    if (sample_hold) begin
      held_r <= level[channel_select];
    end
  end
  // half-lsb offset centres each code, so no trial ever ties
  assign cmp_above = held_r > {dac_code, 1'h0};
endmodule : acc_analog_model

// ==== dv/acc_top_test.sv ====
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_top_test;
  localparam int unsigned STAB = 4;
  logic ref_clk, rst_n, halt_mode, cmp_above, sample_hold, converter_on, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]      s_axi_awaddr, s_axi_araddr, dac_code;
  logic [31:0]     s_axi_wdata, s_axi_rdata, d;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp, r;
  logic [2:0]      channel_select;
  logic [7:0][8:0] level;
  logic [7:0]      ex [8] = '{8'h00, 8'h01, 8'h40, 8'h7F, 8'h80, 8'hA5, 8'hFE, 8'hFF};
  int              fail_count, tests_run, n;
  acc_top #(.STAB_CYCLES(STAB)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .halt_mode(halt_mode), .cmp_above(cmp_above),
    .channel_select(channel_select), .sample_hold(sample_hold), .converter_on(converter_on),
    .dac_code(dac_code), .irq(irq));
  acc_analog_model u_ana (.ref_clk(ref_clk), .channel_select(channel_select), .sample_hold(sample_hold),
    .dac_code(dac_code), .cmp_above(cmp_above), .level(level));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
  endtask : rd
  // polls done; the loop bound is what stops a converter that never finishes
  task automatic wait_done();
    int k;
    k = 0;
    d = 0;
    while (d[7] !== 1'h1 && k < 100) begin
      rd(`ACC_ADDR_CSR, d);
      k++;
    end
    // a converter that never finishes must not slip through silently
    chk(32'(d[7]), 32'h0000_0001);
  endtask : wait_done
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {rst_n, halt_mode, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    for (int c = 0; c < 8; c++) level[c] = (c == 0) ? 9'h000 : {ex[c], 1'h1};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd(`ACC_ADDR_CSR, d); chk(d, 32'h0000_0000);
    rd(`ACC_ADDR_RESULT, d); chk(d, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      wr(`ACC_ADDR_CSR, 32'h0000_0030 | c, r);
      wait_done();
      chk(d, 32'h0000_00A0 | c);
      rd(`ACC_ADDR_RESULT, d); chk(d, ex[c]);
      rd(`ACC_ADDR_CSR, d); chk(d[7], 1'h0);
      chk(irq, 1'h0);
    end
    wr(`ACC_ADDR_RESULT, 32'h0000_0000, r);
    rd(`ACC_ADDR_RESULT, d); chk(d, 32'h0000_00FF);
    @(posedge sample_hold);
    n = -1;
    do begin @(posedge ref_clk); n++; end while (sample_hold);
    do begin @(posedge ref_clk); n++; end while (!sample_hold);
    chk(32'(n), 32'h0000_0040);
    wait_done();
    wr(`ACC_ADDR_CSR, 32'h0000_0023, r);
    rd(`ACC_ADDR_CSR, d); chk(d, 32'h0000_0023);
    wait_done();
    rd(`ACC_ADDR_RESULT, d); chk(d, ex[3]);
    wr(`ACC_ADDR_CSR, 32'h0000_0025, r);
    repeat (40) @(posedge ref_clk);
    wr(`ACC_ADDR_CSR, 32'h0000_0005, r);
    repeat (100) @(posedge ref_clk);
    chk(converter_on, 1'h0);
    rd(`ACC_ADDR_CSR, d); chk(d, 32'h0000_0005);
    rd(`ACC_ADDR_IRQ_STAT, d); chk(d, 32'h0000_0003);
    wr(`ACC_ADDR_IRQ_MASK, 32'h0000_0001, r);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'h1);
    wr(`ACC_ADDR_IRQ_STAT, 32'h0000_0001, r);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'h0);
    rd(`ACC_ADDR_IRQ_STAT, d); chk(d, 32'h0000_0002);
    wr(8'h20, 32'h0000_0000, r); chk(r, `ACC_AXI_SLVERR);
    rd(8'h20, d); chk(d, 32'h0000_0000);
    chk(s_axi_rresp, `ACC_AXI_SLVERR);
    wr(`ACC_ADDR_CSR, 32'h0000_0026, r); chk(r, `ACC_AXI_OKAY);
    wait_done();
    halt_mode <= 1'h1;
    repeat (50) @(posedge ref_clk);
    chk(converter_on, 1'h0);
    rd(`ACC_ADDR_RESULT, d);
    halt_mode <= 1'h0;
    wait_done();
    rd(`ACC_ADDR_RESULT, d); chk(d, ex[6]);
    end_of_test();
  end
endmodule : acc_top_test
